// ---- hw/amd_defines.vh ----
// constants for the operand addressing and class decoder
`ifndef AMD_DEFINES_VH
`define AMD_DEFINES_VH
// ********************************
// addressing mode codes
// ********************************
`define AMD_MODE_INH 3'h0
`define AMD_MODE_IMM 3'h1
`define AMD_MODE_DIR 3'h2
`define AMD_MODE_EXT 3'h3
`define AMD_MODE_IX 3'h4
`define AMD_MODE_IX1 3'h5
`define AMD_MODE_IX2 3'h6
`define AMD_MODE_REL 3'h7
// ********************************
// instruction class codes
// ********************************
`define AMD_CLS_NONE 3'h0
`define AMD_CLS_REGMEM 3'h1
`define AMD_CLS_RMW 3'h2
`define AMD_CLS_JUMP 3'h3
`define AMD_CLS_BRANCH 3'h4
`define AMD_CLS_BITBR 3'h5
`define AMD_CLS_BITMAN 3'h6
`define AMD_CLS_CTRL 3'h7
// ********************************
// opcode fields and fixed values
// ********************************
`define AMD_OPC_HI_MSB 7
`define AMD_OPC_HI_LSB 4
`define AMD_OPC_LO_MSB 3
`define AMD_OPC_LO_LSB 0
`define AMD_BITNUM_MSB 3
`define AMD_BITNUM_LSB 1
`define AMD_OPC_UNSIGNED_MULT 8'h42
`define AMD_OPC_BRANCH_SUB 8'hAD
`define AMD_OPC_TEST_NZ_LO 4'hD
`define AMD_OPC_JUMP_LO 4'hC
`define AMD_OPC_JUMP_SUB_LO 4'hD
`define AMD_OPC_STORE_INDEX_LO 4'hF
`define AMD_ZERO_PAGE 8'h00
`define AMD_RESET_ADDR 16'h0000
`define AMD_RESET_BYTE 8'h00
`define AMD_RESET_MODE 3'h0
`define AMD_RESET_CLS 3'h0
`endif

// ---- hw/amd_decoder.v ----
// operand address generation and instruction class decoder for an 8-bit core
`timescale 1ns/1ps
`include "amd_defines.vh"

// Behaviour
// RL1: two-byte 8-bit offset indexed: address is index plus offset byte, up to 01FE.
// RL2: three-byte 16-bit offset indexed: index plus two-byte offset reaches all memory.
// RL3: first offset byte after opcode is high half, second is low half.
// RL4: taken branch loads pc plus signed offset, else next instruction.
// RL5: branch offset is 8-bit two's complement, forward and backward.
// RL6: relative mode only for branches, branch-to-subroutine and bit test-and-branch.
// RL7: conditions on carry, zero, half-carry, negative, mask, irq pin, always, never.
// RL8: multiply puts product high byte in index, low byte in accumulator.
// RL9: register/memory takes register plus memory by imm, dir, ext or indexed modes.
// RL10: read-modify-write reads, modifies, writes back; test skips the write.
// RL11: read-modify-write only inherent, direct, no-offset and 8-bit offset indexed.
// RL12: 16-bit offset indexed only for load, store, arithmetic, logic, compare, jumps.
// RL13: jump and jump-to-subroutine use dir, ext or any indexed mode, no register.
// RL14: bit test-and-branch is three bytes: opcode, direct address, signed offset.
// RL15: bit number and wanted state come from the opcode itself.
// RL16: bit test reaches the lowest page; branch spans -128 to +127.
// RL17: tested bit is always copied into the carry flag.
// RL18: direct mode uses the operand byte as low address, high byte zero.
// RL19: no-offset indexed uses index as low byte, zero high byte.
// RL20: extended takes first byte high, second byte low.
// RL21: offset is sign-extended and added to the address after the branch.
// RL22: 16-bit indexed sum drops any carry out of bit 15.
module amd_decoder (
  // clock, reset, enable
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  // request from the sequencer
  input wire i_dec_valid,
  input wire [7:0] i_opcode,
  input wire [7:0] i_opnd1,
  input wire [7:0] i_opnd2,
  input wire [15:0] i_pc,
  input wire [7:0] i_acc,
  input wire [7:0] i_idx,
  input wire [7:0] i_mem_data,
  // condition code flags
  input wire i_flag_h,
  input wire i_flag_i,
  input wire i_flag_n,
  input wire i_flag_z,
  input wire i_flag_c,
  // external interrupt pin, asynchronous
  input wire i_irq_pin,
  // decoded answer
  output reg o_dec_valid,
  output reg [2:0] o_mode,
  output reg [2:0] o_class,
  output reg o_illegal,
  output reg [15:0] o_eff_addr,
  output reg [1:0] o_inst_len,
  output reg o_mem_read,
  output reg o_mem_write,
  output reg [15:0] o_next_pc,
  output reg o_branch_taken,
  output reg o_carry_load,
  output reg o_carry_val,
  output reg o_mul_valid,
  output reg [7:0] o_mul_acc,
  output reg [7:0] o_mul_idx
);

  // ********************************
  // pin synchroniser
  // ********************************
  reg irq_meta;
  reg irq_sync;

  // two stages before the branch logic may look at the pin
  // both stages reset to the idle high level, so no false low follows reset
  always @(posedge i_mclk) begin
    if (i_rst) begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end else if (i_ce) begin
      irq_meta <= i_irq_pin;
      irq_sync <= irq_meta;
    end
  end

  // ********************************
  // combinational decode
  // ********************************
  wire [3:0] opc_hi = i_opcode[`AMD_OPC_HI_MSB:`AMD_OPC_HI_LSB];
  wire [3:0] opc_lo = i_opcode[`AMD_OPC_LO_MSB:`AMD_OPC_LO_LSB];
  wire [2:0] bit_num = i_opcode[`AMD_BITNUM_MSB:`AMD_BITNUM_LSB];
  wire [15:0] offset16 = {i_opnd1, i_opnd2}; // [RL3]
  wire [15:0] rel_se = {{8{i_opnd1[7]}}, i_opnd1};
  wire [15:0] rel3_se = {{8{i_opnd2[7]}}, i_opnd2};
  wire [15:0] mul_prod = {8'h00, i_acc} * {8'h00, i_idx}; // widened so the high byte survives
  wire tested_bit = i_mem_data[bit_num]; // [RL15]

  reg [2:0] next_mode;
  reg [2:0] next_class;
  reg next_illegal;
  reg [15:0] next_addr;
  reg [1:0] next_len;
  reg next_rd;
  reg next_wr;
  reg cond;
  reg [15:0] seq_pc;
  reg [15:0] tgt_pc;
  reg next_taken;
  reg next_cload;
  reg next_mul;

  // mode and class from the opcode row, bus read and write by opcode
  always @* begin
    next_mode = `AMD_MODE_INH;
    next_class = `AMD_CLS_NONE;
    next_illegal = 1'b0;
    next_rd = 1'b0;
    next_wr = 1'b0;
    next_mul = 1'b0;
    next_cload = 1'b0;
    case (opc_hi)
      4'h0: begin
        next_mode = `AMD_MODE_REL; // [RL6]
        next_class = `AMD_CLS_BITBR; // [RL14]
        next_rd = 1'b1;
        next_cload = 1'b1; // [RL17]
      end
      4'h1: begin
        next_mode = `AMD_MODE_DIR;
        next_class = `AMD_CLS_BITMAN;
        next_rd = 1'b1;
        next_wr = 1'b1;
      end
      4'h2: begin
        next_mode = `AMD_MODE_REL; // [RL6]
        next_class = `AMD_CLS_BRANCH;
      end
      // rmw rows: no extended or 16-bit indexed forms exist here [RL11]
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        next_class = `AMD_CLS_RMW;
        // multiply sits in an inherent row but works on registers only
        if (i_opcode == `AMD_OPC_UNSIGNED_MULT) begin
          next_class = `AMD_CLS_REGMEM;
          next_mul = 1'b1; // [RL8]
        end
        if (opc_hi == 4'h3) next_mode = `AMD_MODE_DIR;
        else if (opc_hi == 4'h6) next_mode = `AMD_MODE_IX1;
        else if (opc_hi == 4'h7) next_mode = `AMD_MODE_IX;
        else next_mode = `AMD_MODE_INH;
        // inherent rows act on a register and ask for no bus cycle
        next_rd = (opc_hi == 4'h3) || (opc_hi == 4'h6) || (opc_hi == 4'h7);
        next_wr = next_rd && (opc_lo != `AMD_OPC_TEST_NZ_LO); // [RL10]
      end
      4'h8, 4'h9: begin
        next_class = `AMD_CLS_CTRL;
        next_mode = `AMD_MODE_INH;
      end
      // register/memory and jump rows [RL9] [RL12] [RL13]
      default: begin
        if (opc_hi == 4'hA) next_mode = `AMD_MODE_IMM;
        else if (opc_hi == 4'hB) next_mode = `AMD_MODE_DIR;
        else if (opc_hi == 4'hC) next_mode = `AMD_MODE_EXT;
        else if (opc_hi == 4'hD) next_mode = `AMD_MODE_IX2;
        else if (opc_hi == 4'hE) next_mode = `AMD_MODE_IX1;
        else next_mode = `AMD_MODE_IX;
        if (i_opcode == `AMD_OPC_BRANCH_SUB) begin
          next_mode = `AMD_MODE_REL; // [RL6]
          next_class = `AMD_CLS_BRANCH;
        end else if (opc_lo == `AMD_OPC_JUMP_LO || opc_lo == `AMD_OPC_JUMP_SUB_LO) begin
          next_class = `AMD_CLS_JUMP; // [RL13]
          // an immediate jump has no address to go to, so it is flagged
          next_illegal = (opc_hi == 4'hA);
        end else begin
          next_class = `AMD_CLS_REGMEM;
          next_rd = (opc_hi != 4'hA) && (opc_lo != 4'h7) && (opc_lo != `AMD_OPC_STORE_INDEX_LO);
          next_wr = (opc_hi != 4'hA) && ((opc_lo == 4'h7) || (opc_lo == `AMD_OPC_STORE_INDEX_LO));
          next_illegal = (opc_hi == 4'hA) && ((opc_lo == 4'h7) || (opc_lo == `AMD_OPC_STORE_INDEX_LO));
        end
      end
    endcase
  end

  // effective address and length by mode
  always @* begin
    next_addr = `AMD_RESET_ADDR;
    next_len = 2'd1;
    case (next_mode)
      `AMD_MODE_IMM: next_len = 2'd2;
      `AMD_MODE_DIR: begin
        next_addr = {`AMD_ZERO_PAGE, i_opnd1}; // [RL18] [RL16]
        next_len = 2'd2;
      end
      `AMD_MODE_EXT: begin
        next_addr = {i_opnd1, i_opnd2}; // [RL20]
        next_len = 2'd3;
      end
      `AMD_MODE_IX: next_addr = {`AMD_ZERO_PAGE, i_idx}; // [RL19]
      `AMD_MODE_IX1: begin
        next_addr = {8'h00, i_idx} + {8'h00, i_opnd1}; // [RL1]
        next_len = 2'd2;
      end
      `AMD_MODE_IX2: begin
        next_addr = offset16 + {8'h00, i_idx}; // 16-bit target drops carry [RL2] [RL22]
        next_len = 2'd3;
      end
      `AMD_MODE_REL: begin
        if (next_class == `AMD_CLS_BITBR) begin
          next_addr = {`AMD_ZERO_PAGE, i_opnd1}; // [RL14] [RL16]
          next_len = 2'd3;
        end else begin
          next_len = 2'd2;
        end
      end
      // inherent and unknown forms: zero address, one byte, nothing fetched
      default: next_len = 2'd1;
    endcase
  end

  // branch condition from row 2 low nibble, bit test from opcode bit 0
  always @* begin
    cond = 1'b0;
    if (next_class == `AMD_CLS_BITBR) begin
      cond = i_opcode[0] ? ~tested_bit : tested_bit; // [RL15]
    end else if (i_opcode == `AMD_OPC_BRANCH_SUB) begin
      cond = 1'b1; // [RL7]
    end else if (next_class == `AMD_CLS_BRANCH) begin
      case (opc_lo[3:1]) // [RL7]
        3'h0: cond = 1'b1;
        3'h1: cond = ~(i_flag_c | i_flag_z);
        3'h2: cond = ~i_flag_c;
        3'h3: cond = ~i_flag_z;
        3'h4: cond = ~i_flag_h;
        3'h5: cond = ~i_flag_n;
        3'h6: cond = ~i_flag_i;
        // code E branches on a low pin, code F on a high pin
        default: cond = ~irq_sync;
      endcase
      if (opc_lo[0]) cond = ~cond; // odd codes invert: never, set, equal, high pin
    end
  end

  // next pc: sequential, branch target relative to the following instruction, or jump address
  // both adders wrap at 16 bits, the width of the address bus
  always @* begin
    seq_pc = i_pc + {14'h0000, next_len};
    tgt_pc = seq_pc + ((next_class == `AMD_CLS_BITBR) ? rel3_se : rel_se); // [RL5] [RL21]
    next_taken = (next_mode == `AMD_MODE_REL) && cond;
    if (next_class == `AMD_CLS_JUMP) begin
      next_taken = 1'b1;
      tgt_pc = next_addr; // [RL13]
    end
  end

  // ********************************
  // registered answer, one cycle after request
  // ********************************
  // data outputs hold between requests so the sequencer may read them late;
  // pulses fall on an idle cycle so one request never acts twice
  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_dec_valid <= 1'b0;
      o_mode <= `AMD_RESET_MODE;
      o_class <= `AMD_RESET_CLS;
      o_illegal <= 1'b0;
      o_eff_addr <= `AMD_RESET_ADDR;
      o_inst_len <= 2'd0;
      o_mem_read <= 1'b0;
      o_mem_write <= 1'b0;
      o_next_pc <= `AMD_RESET_ADDR;
      o_branch_taken <= 1'b0;
      o_carry_load <= 1'b0;
      o_carry_val <= 1'b0;
      o_mul_valid <= 1'b0;
      o_mul_acc <= `AMD_RESET_BYTE;
      o_mul_idx <= `AMD_RESET_BYTE;
    end else if (i_ce) begin
      o_dec_valid <= i_dec_valid;
      if (i_dec_valid) begin
        o_mode <= next_mode;
        o_class <= next_class;
        o_illegal <= next_illegal;
        o_eff_addr <= next_addr;
        o_inst_len <= next_len;
        o_mem_read <= next_rd;
        o_mem_write <= next_wr; // [RL10]
        o_next_pc <= next_taken ? tgt_pc : seq_pc; // [RL4]
        o_branch_taken <= next_taken;
        o_carry_load <= next_cload; // [RL17]
        o_carry_val <= tested_bit; // [RL17]
        o_mul_valid <= next_mul;
        o_mul_idx <= mul_prod[15:8]; // [RL8]
        o_mul_acc <= mul_prod[7:0]; // [RL8]
      end else begin
        o_mem_read <= 1'b0;
        o_mem_write <= 1'b0;
        o_carry_load <= 1'b0;
        o_mul_valid <= 1'b0;
        o_branch_taken <= 1'b0;
      end
    end
  end

endmodule

// ---- verification/amd_decoder_asserts.sv ----
// assertion checker for the operand address and class decoder
`timescale 1ns/1ps
`include "amd_defines.vh"
module amd_decoder_asserts (
  // watched ports
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  input wire i_dec_valid,
  input wire [7:0] i_opcode,
  input wire [7:0] i_opnd1,
  input wire [7:0] i_opnd2,
  input wire [15:0] i_pc,
  input wire [7:0] i_acc,
  input wire [7:0] i_idx,
  input wire [7:0] i_mem_data,
  input wire o_dec_valid,
  input wire [2:0] o_mode,
  input wire [2:0] o_class,
  input wire [15:0] o_eff_addr,
  input wire o_mem_write,
  input wire [15:0] o_next_pc,
  input wire o_branch_taken,
  input wire o_carry_load,
  input wire o_carry_val,
  input wire [7:0] o_mul_acc,
  input wire [7:0] o_mul_idx
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // a request is an enabled edge with the strobe up
  wire take = i_ce & i_dec_valid;
  sequence s_req(r);
    take && i_opcode[7:4] == r;
  endsequence
  a_ix1_sum: assert property (s_req(4'hE) |=>
    o_eff_addr == $past(i_idx) + $past(i_opnd1)) else $error("byte offset sum wrong");
  a_ix2_sum: assert property (s_req(4'hD) |=>
    o_eff_addr == {$past(i_opnd1), $past(i_opnd2)} + $past(i_idx)) else $error("word offset sum wrong");
  a_direct_page: assert property (s_req(4'hB) |=>
    o_eff_addr == {8'h00, $past(i_opnd1)}) else $error("direct address wrong");
  a_mul_split: assert property (take && i_opcode == `AMD_OPC_UNSIGNED_MULT |=>
    {o_mul_idx, o_mul_acc} == $past(i_acc) * $past(i_idx)) else $error("product placement wrong");
  a_branch_always: assert property (take && i_opcode == 8'h20 |=> o_branch_taken &&
    o_next_pc == $past(i_pc) + 16'h0002 + {{8{$past(i_opnd1[7])}}, $past(i_opnd1)}) else $error("branch target wrong");
  a_bit_carry: assert property (s_req(4'h0) |=> o_carry_load &&
    o_carry_val == $past(i_mem_data[i_opcode[3:1]])) else $error("tested bit not in carry");
  a_rel_owner: assert property (o_dec_valid && o_mode == `AMD_MODE_REL |->
    o_class == `AMD_CLS_BRANCH || o_class == `AMD_CLS_BITBR) else $error("relative mode on wrong class");
  a_rmw_modes: assert property (o_dec_valid && o_class == `AMD_CLS_RMW |->
    o_mode inside {`AMD_MODE_INH, `AMD_MODE_DIR, `AMD_MODE_IX, `AMD_MODE_IX1}) else $error("rmw mode wrong");
  a_test_nowrite: assert property (take && i_opcode[3:0] == 4'hD && i_opcode[7:4] inside {3, 4, 5, 6, 7} |=>
    !o_mem_write) else $error("test wrote back");
endmodule
bind amd_decoder amd_decoder_asserts i_chk (.*);

// ---- verification/amd_mem_model.sv ----
// zero page memory model answering the bit test read
`timescale 1ns/1ps
module amd_mem_model (
  // read port
  input wire [7:0] i_addr,
  output wire [7:0] o_data
);
  // fixed pattern instead of stored bytes, so bit levels differ between addresses
  assign o_data = i_addr ^ 8'h6C;
endmodule

// ---- verification/amd_decoder_tb_top.sv ----
// testbench for the operand address and class decoder
`timescale 1ns/1ps
`include "amd_defines.vh"
module amd_decoder_tb_top;
  reg i_mclk = 0, i_rst = 1, i_ce = 1, i_dec_valid = 0, i_irq_pin = 1;
  reg [7:0] i_opcode = 0, i_opnd1 = 0, i_opnd2 = 0, i_acc = 0, i_idx = 0;
  reg [15:0] i_pc = 16'h0100;
  reg [4:0] fl = 0;
  wire [7:0] mem, o_mul_acc, o_mul_idx;
  wire o_dec_valid, o_illegal, o_mem_read, o_mem_write, o_branch_taken, o_carry_load, o_carry_val, o_mul_valid;
  wire [2:0] o_mode, o_class;
  wire [15:0] o_eff_addr, o_next_pc;
  wire [1:0] o_inst_len;
  integer bad_count = 0, n_checks = 0;
  always #4 i_mclk = ~i_mclk;
  amd_mem_model i_mem (.i_addr(i_opnd1), .o_data(mem));
  amd_decoder i_dut (.*, .i_mem_data(mem), .i_flag_h(fl[4]), .i_flag_i(fl[3]), .i_flag_n(fl[2]),
    .i_flag_z(fl[1]), .i_flag_c(fl[0]));
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one request; the answer is registered at the next edge, looked at just after it
  task run(input [7:0] op, a, b, x, input [4:0] f);
    @(posedge i_mclk);
    i_opcode <= op;
    i_opnd1 <= a;
    i_opnd2 <= b;
    i_acc <= b;
    i_idx <= x;
    fl <= f;
    i_dec_valid <= 1;
    @(posedge i_mclk);
    i_dec_valid <= 0;
    #1 chk("answer", o_dec_valid, 1);
  endtask
  task t_addr;
    run(8'hE6, 8'hFF, 0, 8'hFF, 0);
    chk("ix1", o_eff_addr, 16'h01FE);
    run(8'hD6, 8'hFF, 8'hFF, 8'h02, 0);
    chk("ix2 wrap", o_eff_addr, 16'h0001);
    run(8'hD6, 8'h12, 8'h34, 8'h10, 0);
    chk("ix2 order", o_eff_addr, 16'h1244);
    run(8'hB6, 8'h80, 0, 8'h33, 0);
    chk("dir", o_eff_addr, 16'h0080);
    run(8'hC6, 8'h12, 8'h34, 8'h33, 0);
    chk("ext", o_eff_addr, 16'h1234);
    run(8'hF6, 8'h12, 0, 8'hFF, 0);
    chk("ix", o_eff_addr, 16'h00FF);
    run(8'hA6, 8'h12, 0, 0, 0);
    chk("imm", {o_class, o_mode}, {`AMD_CLS_REGMEM, `AMD_MODE_IMM});
    $display("t_addr done");
  endtask
  task t_branch;
    reg [3:0] k;
    reg [1:0] f;
    run(8'h20, 8'hFE, 0, 0, 0);
    chk("branch back", o_next_pc, 16'h0100);
    run(8'h20, 8'h80, 0, 0, 0);
    chk("branch min", o_next_pc, 16'h0082);
    run(`AMD_OPC_BRANCH_SUB, 8'h7F, 0, 0, 0);
    chk("subroutine max", o_next_pc, 16'h0181);
    chk("subroutine mode", {o_class, o_mode}, {`AMD_CLS_BRANCH, `AMD_MODE_REL});
    run(8'h21, 8'h7F, 0, 0, 0);
    chk("never taken", o_branch_taken, 1'b0);
    chk("never pc", o_next_pc, 16'h0102);
    // carry alone set: carry-clear falls through, not-equal branches
    run(8'h24, 8'h10, 0, 0, 5'h01);
    chk("carry clear", o_branch_taken, 1'b0);
    run(8'h26, 8'h10, 0, 0, 5'h01);
    chk("not equal", o_branch_taken, 1'b1);
    // pin passes a two-flop synchroniser, so let it settle before the pair
    for (f = 0; f < 2; f = f + 1) begin
      @(posedge i_mclk);
      i_irq_pin <= f[0];
      repeat (3) @(posedge i_mclk);
      for (k = 0; k < 8; k = k + 1) begin
        // flags and pin all equal: even codes other than always branch when they are low
        run({4'h2, k[2:0], 1'b0}, 8'h10, 0, 0, {5{f[0]}});
        chk("cond even", o_branch_taken, (k == 0) || !f[0]);
        run({4'h2, k[2:0], 1'b1}, 8'h10, 0, 0, {5{f[0]}});
        chk("cond odd", o_branch_taken, (k != 0) && f[0]);
      end
    end
    $display("t_branch done");
  endtask
  task t_bitbr;
    reg [7:0] m;
    reg [4:0] j;
    reg hit;
    // every bit number, both wanted states, offset at the backward limit
    for (j = 0; j < 16; j = j + 1) begin
      m = {5'h02, j[3:1]} ^ 8'h6C;
      hit = m[j[3:1]] ^ j[0];
      run({4'h0, j[3:0]}, {5'h02, j[3:1]}, 8'h80, 0, 0);
      chk("bit carry", {o_carry_load, o_carry_val}, {1'b1, m[j[3:1]]});
      chk("bit target", o_next_pc, hit ? 16'h0083 : 16'h0103);
      chk("bit addr", o_eff_addr, {11'h002, j[3:1]});
      chk("bit len", o_inst_len, 2'h3);
    end
    $display("t_bitbr done");
  endtask
  task t_class;
    run(`AMD_OPC_UNSIGNED_MULT, 0, 8'h02, 8'h81, 0);
    chk("product", {o_mul_idx, o_mul_acc}, 16'h0102);
    chk("product valid", o_mul_valid, 1'b1);
    run(8'hA7, 8'h12, 0, 0, 0);
    chk("store immediate", {o_illegal, o_mem_write}, 2'b10);
    run(8'h3D, 8'h40, 0, 0, 0);
    chk("test no write", {o_mem_read, o_mem_write}, 2'b10);
    run(8'h3C, 8'h40, 0, 0, 0);
    chk("inc", {o_mem_read, o_mem_write}, 2'b11);
    run(8'h6C, 8'h40, 0, 8'h01, 0);
    chk("inc ix1", {o_class, o_mode}, {`AMD_CLS_RMW, `AMD_MODE_IX1});
    run(8'hDC, 8'h12, 8'h34, 8'h01, 0);
    chk("jump ix2", {o_class, o_mode}, {`AMD_CLS_JUMP, `AMD_MODE_IX2});
    chk("jump dest", o_next_pc, 16'h1235);
    chk("jump legal", o_illegal, 1'b0);
    $display("t_class done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst <= 0;
    t_addr;
    t_branch;
    t_bitbr;
    t_class;
    wrap_up;
  end
  // hang guard
  initial begin
    #100000;
    bad_count = bad_count + 1;
    wrap_up;
  end
endmodule
